// file: core/uiax_pkg.sv
// Constants, types and address decoding for the transceiver control and indirect access block
package uiax_pkg;

  // Processor-side register offsets
  localparam logic [7:0] SFR_ADR_OFS = 8'h96;
  localparam logic [7:0] SFR_XCN_OFS = 8'hd7;
  localparam logic [7:0] SFR_DAT_OFS = 8'h97;

  // Reset values
  localparam logic [6:0] ADR_RST     = 7'h00;
  localparam logic [4:0] XCN_RST     = 5'h00;
  localparam logic [7:0] DAT_RST     = 8'h00;
  localparam logic [3:0] EP_SEL_RST  = 4'h0;

  // Field positions of indirect_address_control
  localparam int ADR_BUSY_BIT = 7;
  localparam int ADR_AUTO_BIT = 6;
  localparam int ADR_PTR_MSB  = 5;

  // Field positions of transceiver_control
  localparam int XCN_PULLUP_BIT = 7;
  localparam int XCN_XCVR_BIT   = 6;
  localparam int XCN_SPEED_BIT  = 5;
  localparam int XCN_TEST_MSB   = 4;
  localparam int XCN_TEST_LSB   = 3;

  // Line drive test modes
  localparam logic [1:0] TEST_NORMAL = 2'h0;
  localparam logic [1:0] TEST_DIFF1  = 2'h1;
  localparam logic [1:0] TEST_DIFF0  = 2'h2;
  localparam logic [1:0] TEST_SE0    = 2'h3;

  // Core register map
  localparam logic [5:0] CA_FUNC_ADDR   = 6'h00;
  localparam logic [5:0] CA_POWER       = 6'h01;
  localparam logic [5:0] CA_IN_INT      = 6'h02;
  localparam logic [5:0] CA_OUT_INT     = 6'h04;
  localparam logic [5:0] CA_CM_INT      = 6'h06;
  localparam logic [5:0] CA_IN_IE       = 6'h07;
  localparam logic [5:0] CA_OUT_IE      = 6'h09;
  localparam logic [5:0] CA_CM_IE       = 6'h0b;
  localparam logic [5:0] CA_FRAME_LO    = 6'h0c;
  localparam logic [5:0] CA_FRAME_HI    = 6'h0d;
  localparam logic [5:0] CA_EP_SEL      = 6'h0e;
  localparam logic [5:0] CA_CLK_RECOVER = 6'h0f;
  localparam logic [5:0] CA_EP0_CSR     = 6'h11;
  localparam logic [5:0] CA_IN_CSR_HI   = 6'h12;
  localparam logic [5:0] CA_OUT_CSR_LO  = 6'h14;
  localparam logic [5:0] CA_OUT_CSR_HI  = 6'h15;
  localparam logic [5:0] CA_EP0_CNT     = 6'h16;
  localparam logic [5:0] CA_OUT_CNT_HI  = 6'h17;
  localparam logic [5:0] CA_FIFO_FIRST  = 6'h20;
  localparam logic [5:0] CA_FIFO_LAST   = 6'h23;
  localparam logic [3:0] EP_SEL_MAX     = 4'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RD   = 3'b010,
    ST_WR   = 3'b100
  } uiax_state_t;

  typedef struct packed {
    logic       we;
    logic [5:0] addr;
    logic [7:0] wdata;
  } uiax_acc_t;

  typedef struct packed {
    logic intr;
    logic common;
    logic indexed;
    logic fifo;
    logic local_sel;
  } uiax_region_t;

  typedef struct packed {
    logic vbus;
    logic plus;
    logic minus;
  } uiax_pins_t;

  function automatic uiax_region_t core_region(input logic [5:0] a);
    uiax_region_t r;
    r           = '0;
    r.intr      = (a == CA_IN_INT) || (a == CA_OUT_INT) || (a == CA_CM_INT) ||
                  (a == CA_IN_IE) || (a == CA_OUT_IE) || (a == CA_CM_IE);
    r.common    = (a == CA_FUNC_ADDR) || (a == CA_POWER) || (a == CA_FRAME_LO) ||
                  (a == CA_FRAME_HI) || (a == CA_CLK_RECOVER);
    r.local_sel = (a == CA_EP_SEL);
    r.fifo      = (a >= CA_FIFO_FIRST) && (a <= CA_FIFO_LAST);
    r.indexed   = (a == CA_EP0_CSR) || (a == CA_IN_CSR_HI) || (a == CA_OUT_CSR_LO) ||
                  (a == CA_OUT_CSR_HI) || (a == CA_EP0_CNT) || (a == CA_OUT_CNT_HI);
    return r;
  endfunction : core_region

endpackage : uiax_pkg

// file: core/uiax_core_map.sv
// Core register map decode and the endpoint selector register
`timescale 1ns/1ns
`default_nettype none
module uiax_core_map
  import uiax_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire uiax_acc_t    acc_i,
  input  wire logic         done_i,
  input  wire logic [7:0]   core_rdata_i,
  output uiax_region_t      region_o,
  output logic              mapped_o,
  output logic [1:0]        ep_o,
  output logic [7:0]        rdata_o
);

  logic [3:0] sel_reg;
  logic [3:0] sel_next;

  always_comb begin
    region_o = core_region(acc_i.addr);
    // Indexed access with a reserved selector never reaches the core
    mapped_o = region_o.intr || region_o.common || region_o.fifo ||
               (region_o.indexed && (sel_reg <= EP_SEL_MAX));
    ep_o     = sel_reg[1:0];
    if (region_o.local_sel) begin
      rdata_o = {4'h0, sel_reg};
    end else if (mapped_o) begin
      rdata_o = core_rdata_i;
    end else begin
      rdata_o = 8'h00;
    end
    sel_next = sel_reg;
    if (done_i && acc_i.we && region_o.local_sel) begin
      sel_next = acc_i.wdata[3:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_reg <= EP_SEL_RST;
    end else begin
      sel_reg <= sel_next;
    end
  end

endmodule : uiax_core_map
`default_nettype wire

// file: core/uiax_ctrl.sv
// Transceiver control and indirect core register access bridge
// How it works
// - Pull-up off when attach bit clear
// - Speed bit picks rate and pull-up line
// - Transceiver enable bit suspends or runs transceiver
// - Test field forces the line levels
// - Status shows differential line state
// - Status shows each line level
// - Data port accesses the pointed core register
// - Pointer is six low address bits
// - Writing busy one starts a core read
// - Busy holds until read data loaded
// - Auto-read restarts read on data read
// - Interrupt flag and enable addresses fixed
// - Common register and FIFO addresses fixed
// - Indexed register addresses fixed
// - Endpoint selector low four bits, 4-15 reserved
`timescale 1ns/1ns
`default_nettype none
module uiax_ctrl
  import uiax_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic        sfr_wr_i,
  input  wire logic        sfr_rd_i,
  input  wire logic [7:0]  sfr_wdata_i,
  output logic [7:0]       sfr_rdata_o,
  output logic             core_req_o,
  output logic             core_we_o,
  output logic [5:0]       core_addr_o,
  output logic [1:0]       core_ep_o,
  output logic [7:0]       core_wdata_o,
  input  wire logic [7:0]  core_rdata_i,
  input  wire logic        core_ack_i,
  input  wire logic        vbus_i,
  input  wire logic        line_plus_i,
  input  wire logic        line_minus_i,
  input  wire logic        tx_plus_i,
  input  wire logic        tx_minus_i,
  input  wire logic        tx_oe_i,
  output logic             line_plus_o,
  output logic             line_minus_o,
  output logic             line_plus_oe_o,
  output logic             line_minus_oe_o,
  output logic             pullup_plus_o,
  output logic             pullup_minus_o,
  output logic             xcvr_enable_o,
  output logic             full_speed_o
);

  // Access state
  uiax_state_t  state_reg;
  uiax_state_t  state_next;
  uiax_acc_t    acc_reg;
  uiax_acc_t    acc_next;
  logic [6:0]   adr_reg;
  logic [6:0]   adr_next;
  logic [4:0]   xcn_reg;
  logic [4:0]   xcn_next;
  logic [7:0]   dat_reg;
  logic [7:0]   dat_next;
  logic [7:0]   rdata_reg;
  logic [7:0]   rdata_next;
  logic         idle;
  logic         busy;
  logic         wr_adr;
  logic         wr_xcn;
  logic         wr_dat;
  logic         rd_dat;
  logic         start_rd;
  logic         start_wr;
  logic         done;
  logic [5:0]   ptr;
  logic [5:0]   start_ptr;

  // Map outputs
  uiax_region_t region;
  logic         mapped;
  logic [1:0]   ep_sel;
  logic [7:0]   map_rdata;

  // Line state
  uiax_pins_t   sync1_reg;
  uiax_pins_t   sync1_next;
  uiax_pins_t   sync2_reg;
  uiax_pins_t   sync2_next;
  logic         diff_reg;
  logic         diff_next;
  logic         plus_reg;
  logic         plus_next;
  logic         minus_reg;
  logic         minus_next;
  logic         plus_oe_reg;
  logic         plus_oe_next;
  logic         minus_oe_reg;
  logic         minus_oe_next;
  logic         pu_plus_reg;
  logic         pu_plus_next;
  logic         pu_minus_reg;
  logic         pu_minus_next;
  logic         pullup_en;
  logic         xcvr_en;
  logic         speed;
  logic [1:0]   test;

  assign pullup_en = xcn_reg[XCN_PULLUP_BIT - 3];
  assign xcvr_en   = xcn_reg[XCN_XCVR_BIT - 3];
  assign speed     = xcn_reg[XCN_SPEED_BIT - 3];
  assign test      = xcn_reg[XCN_TEST_MSB - 3:XCN_TEST_LSB - 3];
  assign ptr       = adr_reg[ADR_PTR_MSB:0];
  assign idle      = (state_reg == ST_IDLE);
  assign busy      = (state_reg == ST_RD);

  uiax_core_map u_map (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .acc_i        (acc_reg),
    .done_i       (done),
    .core_rdata_i (core_rdata_i),
    .region_o     (region),
    .mapped_o     (mapped),
    .ep_o         (ep_sel),
    .rdata_o      (map_rdata)
  );

  // Core side handshake; unmapped or local targets complete without the core
  assign core_req_o   = !idle && mapped;
  assign core_we_o    = (state_reg == ST_WR);
  assign core_addr_o  = acc_reg.addr;
  assign core_ep_o    = ep_sel;
  assign core_wdata_o = acc_reg.wdata;
  assign done         = !idle && (mapped ? core_ack_i : 1'b1);

  always_comb begin
    wr_adr     = sfr_wr_i && (sfr_addr_i == SFR_ADR_OFS);
    wr_xcn     = sfr_wr_i && (sfr_addr_i == SFR_XCN_OFS);
    wr_dat     = sfr_wr_i && (sfr_addr_i == SFR_DAT_OFS);
    rd_dat     = sfr_rd_i && (sfr_addr_i == SFR_DAT_OFS);
    start_ptr  = wr_adr ? sfr_wdata_i[ADR_PTR_MSB:0] : ptr;
    start_rd   = idle && ((wr_adr && sfr_wdata_i[ADR_BUSY_BIT]) ||
                          (rd_dat && adr_reg[ADR_AUTO_BIT]));
    start_wr   = idle && wr_dat;
    state_next = state_reg;
    acc_next   = acc_reg;
    adr_next   = adr_reg;
    xcn_next   = xcn_reg;
    dat_next   = dat_reg;
    rdata_next = rdata_reg;
    if (wr_adr) begin
      adr_next = sfr_wdata_i[ADR_AUTO_BIT:0];
    end
    if (wr_xcn) begin
      xcn_next = sfr_wdata_i[XCN_PULLUP_BIT:XCN_TEST_LSB];
    end
    case (state_reg)
      ST_IDLE: begin
        if (start_rd) begin
          state_next     = ST_RD;
          acc_next.we    = 1'b0;
          acc_next.addr  = start_ptr;
          acc_next.wdata = 8'h00;
        end else if (start_wr) begin
          state_next     = ST_WR;
          acc_next.we    = 1'b1;
          acc_next.addr  = ptr;
          acc_next.wdata = sfr_wdata_i;
          dat_next       = sfr_wdata_i;
        end
      end
      ST_RD: begin
        if (done) begin
          state_next = ST_IDLE;
          dat_next   = map_rdata;
        end
      end
      ST_WR: begin
        if (done) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (sfr_rd_i) begin
      if (sfr_addr_i == SFR_ADR_OFS) begin
        rdata_next = {busy, adr_reg};
      end else if (sfr_addr_i == SFR_XCN_OFS) begin
        rdata_next = {xcn_reg, diff_reg, sync2_reg.plus, sync2_reg.minus};
      end else if (sfr_addr_i == SFR_DAT_OFS) begin
        rdata_next = dat_reg;
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      acc_reg   <= '0;
      adr_reg   <= ADR_RST;
      xcn_reg   <= XCN_RST;
      dat_reg   <= DAT_RST;
      rdata_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      acc_reg   <= acc_next;
      adr_reg   <= adr_next;
      xcn_reg   <= xcn_next;
      dat_reg   <= dat_next;
      rdata_reg <= rdata_next;
    end
  end

  assign sfr_rdata_o = rdata_reg;

  // Line side: pin sampling, pull-up placement and drive
  always_comb begin
    sync1_next    = '{vbus: vbus_i, plus: line_plus_i, minus: line_minus_i};
    sync2_next    = sync1_reg;
    diff_next     = diff_reg;
    if (!xcvr_en) begin
      diff_next = 1'b0;
    end else if (sync2_reg.plus != sync2_reg.minus) begin
      diff_next = sync2_reg.plus;
    end
    pu_plus_next  = pullup_en && sync2_reg.vbus && speed;
    pu_minus_next = pullup_en && sync2_reg.vbus && !speed;
    case (test)
      TEST_DIFF1: begin
        plus_next  = 1'b1;
        minus_next = 1'b0;
      end
      TEST_DIFF0: begin
        plus_next  = 1'b0;
        minus_next = 1'b1;
      end
      TEST_SE0: begin
        plus_next  = 1'b0;
        minus_next = 1'b0;
      end
      default: begin
        plus_next  = tx_plus_i;
        minus_next = tx_minus_i;
      end
    endcase
    plus_oe_next  = xcvr_en && ((test != TEST_NORMAL) || tx_oe_i);
    minus_oe_next = plus_oe_next;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_reg    <= '0;
      sync2_reg    <= '0;
      diff_reg     <= 1'b0;
      plus_reg     <= 1'b0;
      minus_reg    <= 1'b0;
      plus_oe_reg  <= 1'b0;
      minus_oe_reg <= 1'b0;
      pu_plus_reg  <= 1'b0;
      pu_minus_reg <= 1'b0;
    end else begin
      sync1_reg    <= sync1_next;
      sync2_reg    <= sync2_next;
      diff_reg     <= diff_next;
      plus_reg     <= plus_next;
      minus_reg    <= minus_next;
      plus_oe_reg  <= plus_oe_next;
      minus_oe_reg <= minus_oe_next;
      pu_plus_reg  <= pu_plus_next;
      pu_minus_reg <= pu_minus_next;
    end
  end

  assign line_plus_o     = plus_reg;
  assign line_minus_o    = minus_reg;
  assign line_plus_oe_o  = plus_oe_reg;
  assign line_minus_oe_o = minus_oe_reg;
  assign pullup_plus_o   = pu_plus_reg;
  assign pullup_minus_o  = pu_minus_reg;
  assign xcvr_enable_o   = xcvr_en;
  assign full_speed_o    = speed;

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_busy_write;
    idle && wr_adr && sfr_wdata_i[ADR_BUSY_BIT];
  endsequence

  sequence s_auto_read;
    idle && rd_dat && adr_reg[ADR_AUTO_BIT];
  endsequence

  a_busy_on_start: assert property (
    s_busy_write |=> busy && (core_addr_o == $past(sfr_wdata_i[5:0])) && !core_we_o)
    else $error("busy write did not start a core read");

  a_zero_no_start: assert property (
    idle && wr_adr && !sfr_wdata_i[ADR_BUSY_BIT] && !sfr_rd_i |=> idle)
    else $error("busy zero write started an access");

  a_busy_clear_load: assert property (
    busy && done |=> !busy && (dat_reg == $past(map_rdata)))
    else $error("busy cleared without loading data");

  a_busy_holds: assert property (
    busy && !done |=> busy)
    else $error("busy dropped before data arrived");

  a_auto_restart: assert property (
    s_auto_read |=> busy && (core_addr_o == $past(ptr)) && (ptr == $past(ptr)))
    else $error("auto read did not restart at same pointer");

  a_data_target: assert property (
    idle && wr_dat |=> core_we_o && (core_addr_o == $past(ptr)) &&
                       (core_wdata_o == $past(sfr_wdata_i)))
    else $error("data write not sent to pointed register");

  a_pullup_detach: assert property (
    !pullup_en |=> !pullup_plus_o && !pullup_minus_o)
    else $error("pull-up connected while detached");

  a_pullup_place: assert property (
    pullup_en && sync2_reg.vbus |=> (pullup_plus_o == $past(speed)) &&
                                    (pullup_minus_o == !$past(speed)))
    else $error("pull-up on wrong line for speed");

  a_test_force: assert property (
    xcvr_en && (test == TEST_DIFF0) |=> !line_plus_o && line_minus_o && line_plus_oe_o)
    else $error("test mode did not force lines");

  a_xcvr_off: assert property (
    !xcvr_en |=> !line_plus_oe_o && !line_minus_oe_o && !diff_reg)
    else $error("suspended transceiver drove lines");

endmodule : uiax_ctrl
`default_nettype wire

// file: tb/uiax_core_model.sv
// Behavioural model of the core register space behind the indirect port
`timescale 1ns/1ns
`default_nettype none
module uiax_core_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [5:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic [1:0]  lat_i,
  output logic             ack_o,
  output logic [7:0]       rdata_o,
  output logic [15:0]      cnt_o
);
  logic [7:0] mem [64];
  logic [7:0] last_reg;
  logic [1:0] wait_reg;
  logic       done_reg;

  // Read data only holds in the ack cycle; elsewhere it shows the inverse
  assign rdata_o = ack_o ? last_reg : ~last_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      last_reg <= 8'h00;
      wait_reg <= 2'h0;
      done_reg <= 1'b0;
      cnt_o <= 16'h0000;
      for (int i = 0; i < 64; i++) mem[i] <= 8'h00;
    end else begin
      ack_o <= 1'b0;
      if (!req_i) begin
        wait_reg <= 2'h0;
        done_reg <= 1'b0;
      end else if (!done_reg) begin
        if (wait_reg >= lat_i) begin
          ack_o <= 1'b1;
          done_reg <= 1'b1;
          cnt_o <= cnt_o + 16'h0001;
          if (we_i) mem[addr_i] <= wdata_i;
          else begin
            last_reg <= mem[addr_i];
            // FIFO places hand out the next byte on each read
            if (addr_i[5]) mem[addr_i] <= mem[addr_i] + 8'h01;
          end
        end else wait_reg <= wait_reg + 2'h1;
      end
    end
  end
endmodule : uiax_core_model
`default_nettype wire

// file: tb/usb_indirect_access_xcvr_ctrl_bench.sv
// Self-checking testbench for the transceiver control and indirect access block
`timescale 1ns/1ns
`default_nettype none
module usb_indirect_access_xcvr_ctrl_bench;
  import uiax_pkg::*;
  typedef struct packed {logic [7:0] mask; logic [7:0] val;} uiax_note_t;
  localparam logic [5:0] MAP [17] = '{CA_FUNC_ADDR, CA_POWER, CA_IN_INT, CA_OUT_INT,
    CA_CM_INT, CA_IN_IE, CA_OUT_IE, CA_CM_IE, CA_FRAME_LO, CA_FRAME_HI, CA_CLK_RECOVER,
    CA_EP0_CSR, CA_IN_CSR_HI, CA_OUT_CSR_LO, CA_OUT_CSR_HI, CA_EP0_CNT, CA_OUT_CNT_HI};
  logic clk_i = 1'b0, rst_i = 1'b1, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, rd_pend = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o, core_wdata_o, core_rdata;
  logic vbus_i = 1'b0, line_plus_i = 1'b0, line_minus_i = 1'b0;
  logic tx_plus_i = 1'b0, tx_minus_i = 1'b0, tx_oe_i = 1'b0;
  logic core_req_o, core_we_o, core_ack, line_plus_o, line_minus_o, line_plus_oe_o;
  logic line_minus_oe_o, pullup_plus_o, pullup_minus_o, xcvr_enable_o, full_speed_o;
  logic [5:0] core_addr_o;
  logic [1:0] core_ep_o;
  logic [1:0] lat = 2'h0;
  logic [15:0] cnt, seed = 16'h5ac1;
  uiax_note_t notes[$];
  uiax_note_t note;
  int errors = 0;
  int compares = 0;

  always #4 clk_i = ~clk_i;

  uiax_ctrl uiax_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .core_req_o(core_req_o), .core_we_o(core_we_o),
    .core_addr_o(core_addr_o), .core_ep_o(core_ep_o), .core_wdata_o(core_wdata_o),
    .core_rdata_i(core_rdata), .core_ack_i(core_ack), .vbus_i(vbus_i),
    .line_plus_i(line_plus_i), .line_minus_i(line_minus_i), .tx_plus_i(tx_plus_i),
    .tx_minus_i(tx_minus_i), .tx_oe_i(tx_oe_i), .line_plus_o(line_plus_o),
    .line_minus_o(line_minus_o), .line_plus_oe_o(line_plus_oe_o),
    .line_minus_oe_o(line_minus_oe_o), .pullup_plus_o(pullup_plus_o),
    .pullup_minus_o(pullup_minus_o), .xcvr_enable_o(xcvr_enable_o),
    .full_speed_o(full_speed_o));

  uiax_core_model uiax_core_model_inst (.clk_i(clk_i), .rst_i(rst_i), .req_i(core_req_o),
    .we_i(core_we_o), .addr_i(core_addr_o), .wdata_i(core_wdata_o), .lat_i(lat),
    .ack_o(core_ack), .rdata_o(core_rdata), .cnt_o(cnt));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic conclude();
    $display("Counts: compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(posedge clk_i);
    #1;
    sfr_wr_i = 1'b0;
  endtask : wr

  // Mask zero means the read is a poll and its value is not judged
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                    output logic [7:0] v);
    @(posedge clk_i);
    #1;
    notes.push_back('{m, e});
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(posedge clk_i);
    #1;
    sfr_rd_i = 1'b0;
    v = sfr_rdata_o;
  endtask : rd

  task automatic wait_idle();
    logic [7:0] v;
    int n;
    v = 8'h80;
    for (n = 0; n < 40 && v[7] !== 1'b0; n++) rd(SFR_ADR_OFS, 8'h00, 8'h00, v);
    chk("busy", 8'h00, {7'h00, v[7]});
  endtask : wait_idle

  task automatic ind_wr(input logic [5:0] a, input logic [7:0] d);
    int n;
    wait_idle();
    wr(SFR_ADR_OFS, {2'b00, a});
    wr(SFR_DAT_OFS, d);
    for (n = 0; n < 40 && core_req_o !== 1'b0; n++) begin
      @(posedge clk_i);
      #1;
    end
    // One more edge lets a local selector write land before anyone looks at it
    @(posedge clk_i);
    #1;
    chk("core_req_o", 8'h00, {7'h00, core_req_o});
  endtask : ind_wr

  task automatic ind_rd(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] v;
    wr(SFR_ADR_OFS, {2'b10, a});
    wait_idle();
    rd(SFR_DAT_OFS, 8'hff, e, v);
  endtask : ind_rd

  always @(posedge clk_i) rd_pend <= sfr_rd_i;
  always @(negedge clk_i) begin
    if (rd_pend && notes.size() > 0) begin
      note = notes.pop_front();
      if (note.mask != 8'h00) begin
        chk("sfr_rdata_o", note.val & note.mask, sfr_rdata_o & note.mask);
      end
    end
  end

  initial begin
    #400000;
    errors++;
    conclude();
  end

  initial begin
    logic [7:0] v;
    logic [7:0] d;
    logic [7:0] stash [17];
    logic [1:0] m;
    logic p;
    logic q;
    logic [15:0] c0;
    int i;
    repeat (12) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    rd(SFR_ADR_OFS, 8'hff, 8'h00, v);
    rd(SFR_XCN_OFS, 8'hff, 8'h00, v);
    rd(SFR_DAT_OFS, 8'hff, DAT_RST, v);
    rd(8'h55, 8'hff, 8'h00, v);
    $display("Test reset values done");
    for (i = 0; i < 16; i++) begin
      vbus_i = i[2];
      wr(SFR_XCN_OFS, {i[0], i[3], i[1], 5'h00});
      repeat (4) @(posedge clk_i);
      #1;
      chk("pullup_plus_o", {7'h00, i[0] & i[2] & i[1]}, {7'h00, pullup_plus_o});
      chk("pullup_minus_o", {7'h00, i[0] & i[2] & !i[1]}, {7'h00, pullup_minus_o});
      chk("xcvr_enable_o", {7'h00, i[3]}, {7'h00, xcvr_enable_o});
      chk("full_speed_o", {7'h00, i[1]}, {7'h00, full_speed_o});
    end
    $display("Test pull-up and speed done");
    for (i = 0; i < 9; i++) begin
      seed = lfsr_next(seed);
      m = i[1:0];
      tx_oe_i = i[2];
      tx_plus_i = seed[0];
      tx_minus_i = seed[1];
      wr(SFR_XCN_OFS, {1'b0, i < 8, 1'b0, m, 3'b000});
      @(posedge clk_i);
      #1;
      p = (m == TEST_DIFF1) || (m == TEST_NORMAL && tx_plus_i);
      q = (m == TEST_DIFF0) || (m == TEST_NORMAL && tx_minus_i);
      d = {7'h00, (i < 8) && (m != TEST_NORMAL || tx_oe_i)};
      chk("line_plus_oe_o", d, {7'h00, line_plus_oe_o});
      chk("line_minus_oe_o", d, {7'h00, line_minus_oe_o});
      if (d[0]) chk("line_levels", {6'h00, p, q}, {6'h00, line_plus_o, line_minus_o});
    end
    $display("Test line drive done");
    for (i = 0; i < 4; i++) begin
      p = (i != 1);
      q = (i == 1 || i == 2);
      line_plus_i = p;
      line_minus_i = q;
      wr(SFR_XCN_OFS, 8'h40);
      repeat (4) @(posedge clk_i);
      rd(SFR_XCN_OFS, 8'hff, {5'b01000, i == 0 || i == 3, p, q}, v);
    end
    $display("Test line status done");
    ind_wr(CA_EP_SEL, 8'h02);
    chk("core_ep_o", 8'h02, {6'h00, core_ep_o});
    c0 = cnt;
    for (i = 0; i < 17; i++) begin
      seed = lfsr_next(seed);
      lat = seed[1:0];
      stash[i] = seed[15:8];
      ind_wr(MAP[i], stash[i]);
    end
    for (i = 0; i < 17; i++) ind_rd(MAP[i], stash[i]);
    chk("core_count", 8'd34, cnt[7:0] - c0[7:0]);
    $display("Test core map done");
    ind_wr(CA_EP_SEL, 8'h05);
    ind_rd(CA_EP_SEL, 8'h05);
    c0 = cnt;
    ind_rd(CA_EP0_CSR, 8'h00);
    ind_rd(6'h03, 8'h00);
    chk("core_count", 8'h00, cnt[7:0] - c0[7:0]);
    ind_wr(CA_EP_SEL, 8'h00);
    $display("Test endpoint selector done");
    lat = 2'h3;
    wr(SFR_ADR_OFS, {2'b10, CA_POWER});
    rd(SFR_ADR_OFS, 8'hff, {2'b10, CA_POWER}, v);
    wait_idle();
    c0 = cnt;
    wr(SFR_ADR_OFS, {2'b00, CA_POWER});
    rd(SFR_ADR_OFS, 8'hff, {2'b00, CA_POWER}, v);
    rd(SFR_DAT_OFS, 8'hff, stash[1], v);
    chk("core_count", 8'h00, cnt[7:0] - c0[7:0]);
    $display("Test busy flag done");
    seed = lfsr_next(seed);
    d = seed[7:0];
    lat = 2'h1;
    ind_wr(6'h21, d);
    wr(SFR_ADR_OFS, 8'hc0 | 8'h21);
    wait_idle();
    rd(SFR_DAT_OFS, 8'hff, d, v);
    wait_idle();
    rd(SFR_DAT_OFS, 8'hff, d + 8'h01, v);
    wait_idle();
    wr(SFR_ADR_OFS, 8'h21);
    c0 = cnt;
    rd(SFR_DAT_OFS, 8'hff, d + 8'h02, v);
    rd(SFR_DAT_OFS, 8'hff, d + 8'h02, v);
    repeat (4) @(posedge clk_i);
    chk("core_count", 8'h00, cnt[7:0] - c0[7:0]);
    $display("Test auto-read done");
    conclude();
  end
endmodule : usb_indirect_access_xcvr_ctrl_bench
`default_nettype wire
